// File: cdhp_ctrl.sv
// Cable detect and hot-plug assert control for four receiver ports.
// Assumes a simple register port at the printed offsets, 1-cycle read latency.
// Port index 3 is port A, index 0 is port D, matching register bit order.

// Operation
// (RULE_01) Raw cable bit per port mirrors supply sense
// (RULE_02) Raw readbacks valid in every receiver mode
// (RULE_03) Filter rises after input high full timer
// (RULE_04) Filter drops at once on input change
// (RULE_05) Timer counts two-oscillator units, default 1011000
// (RULE_06) Bypass bit zero enables, one bypasses filter
// (RULE_07) Filter runs from always-on internal clock
// (RULE_08) Filtered detect feeds flags and receiver reset
// (RULE_09) Selected inactive port resets receiver unless disabled
// (RULE_10) Software disables cable reset when pins float
// (RULE_11) Manual select drives manual levels, default on
// (RULE_12) Manual level per port, default low
// (RULE_13) Policy field ignored under manual select
// (RULE_14) Policy 00 follows internal E-EDID active
// (RULE_15) Policy 01 rises delayed, falls on unplug
// (RULE_16) Policy 10 needs E-EDID and delayed cable
// (RULE_17) Policy 11 adds manual level to 10
// (RULE_18) Delay field in 100 ms steps, default 1010
// (RULE_19) Per-port tristate bit, default driven
// (RULE_20) E-EDID active is enabled status input
// (RULE_21) Status bit shows hot-plug driven high
// (RULE_22) Events from filtered or bypassed detect
// (RULE_23) Delay counter restarts when detect falls
module cdhp_ctrl
    import cdhp_pkg::*;
#(
    parameter logic [CDHP_STEP_W-1:0] HP_STEP_CYCLES = CDHP_HP_STEP_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [3:0] port_supply_sense_i,
    input wire logic [3:0] port_internal_edid_active_i,
    input wire logic [1:0] rx_port_sel_i,
    output logic [3:0] hotplug_pin_o,
    output logic [3:0] hotplug_pin_oe_o,
    output logic [3:0] cable_det_filtered_o,
    output logic rx_section_reset_o
);

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr == off);
    endfunction : reg_hit

    ////////////////////////////////////////////////////////////////////////////
    // Supply sense synchroniser
    logic [3:0] sense_meta_reg;
    logic [3:0] sense_sync_reg;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sense_meta_reg <= 4'h0;
            sense_sync_reg <= 4'h0;
        end else begin
            sense_meta_reg <= port_supply_sense_i;
            sense_sync_reg <= sense_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] hp_manual_reg;
    logic [7:0] hp_manual_next;
    logic [7:0] cable_rst_reg;
    logic [7:0] cable_rst_next;
    logic [7:0] deglitch_reg;
    logic [7:0] deglitch_next;
    logic [7:0] hp_policy_reg;
    logic [7:0] hp_policy_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [3:0] hp_reg;
    logic [3:0] hp_next;

    logic [3:0] man_level;
    logic [3:0] hiz;
    logic manual_sel;
    cdhp_policy_e policy;
    logic [3:0] delay_sel;
    logic [3:0] hp_status;

    assign man_level = hp_manual_reg[CDHP_MAN_LEVEL_LSB +: 4];
    assign hiz = hp_manual_reg[CDHP_HIZ_LSB +: 4];
    assign manual_sel = hp_policy_reg[CDHP_MANUAL_SEL_BIT];
    assign policy = cdhp_policy_e'(hp_policy_reg[CDHP_POLICY_LSB +: 2]);
    assign delay_sel = hp_policy_reg[CDHP_DELAY_LSB +: 4]; // [RULE_18]
    assign hp_status = hp_reg & ~hiz; // [RULE_21]

    always_comb begin
        hp_manual_next = hp_manual_reg;
        cable_rst_next = cable_rst_reg;
        deglitch_next = deglitch_reg;
        hp_policy_next = hp_policy_reg;
        if (reg_wr_i) begin
            if (reg_hit(reg_addr_i, CDHP_OFF_HP_MANUAL)) begin
                hp_manual_next = reg_wdata_i; // [RULE_12] [RULE_19]
            end
            if (reg_hit(reg_addr_i, CDHP_OFF_CABLE_RST)) begin
                cable_rst_next = reg_wdata_i;
            end
            if (reg_hit(reg_addr_i, CDHP_OFF_DEGLITCH)) begin
                deglitch_next = reg_wdata_i;
            end
            if (reg_hit(reg_addr_i, CDHP_OFF_HP_POLICY)) begin
                hp_policy_next = reg_wdata_i;
            end
        end
    end

    // Read data; unmapped offsets and read-only writes return or store nothing
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd_i) begin
            if (reg_hit(reg_addr_i, CDHP_OFF_HP_MANUAL)) begin
                rdata_next = hp_manual_reg;
            end else if (reg_hit(reg_addr_i, CDHP_OFF_HP_STATUS)) begin
                rdata_next = {4'h0, hp_status}; // [RULE_21]
            end else if (reg_hit(reg_addr_i, CDHP_OFF_CABLE_RST)) begin
                rdata_next = cable_rst_reg;
            end else if (reg_hit(reg_addr_i, CDHP_OFF_DEGLITCH)) begin
                rdata_next = deglitch_reg;
            end else if (reg_hit(reg_addr_i, CDHP_OFF_HP_POLICY)) begin
                rdata_next = hp_policy_reg;
            end else if (reg_hit(reg_addr_i, CDHP_OFF_CABLE_RAW)) begin
                // No mode gating on purpose [RULE_02]
                rdata_next = {4'h0, sense_sync_reg}; // [RULE_01]
            end else begin
                rdata_next = 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hp_manual_reg <= CDHP_RST_HP_MANUAL;
            cable_rst_reg <= CDHP_RST_CABLE_RST;
            deglitch_reg <= CDHP_RST_DEGLITCH; // [RULE_05] [RULE_06]
            hp_policy_reg <= CDHP_RST_HP_POLICY; // [RULE_11] [RULE_15] [RULE_18]
            rdata_reg <= 8'h00;
        end else begin
            hp_manual_reg <= hp_manual_next;
            cable_rst_reg <= cable_rst_next;
            deglitch_reg <= deglitch_next;
            hp_policy_reg <= hp_policy_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Deglitch filters and hot-plug delay
    // The oscillator is approximated by sys_clk_i; one unit rounds to one cycle [RULE_07]
    logic [3:0] det;
    logic [3:0] dly_reg;
    logic [3:0] dly_next;
    logic [CDHP_STEP_W-1:0] cyc_reg [4];
    logic [CDHP_STEP_W-1:0] cyc_next [4];
    logic [3:0] step_reg [4];
    logic [3:0] step_next [4];

    for (genvar i = 0; i < 4; i++) begin : g_port
        cdhp_deglitch u_deglitch (
            .sys_clk_i(sys_clk_i),
            .resetn_i(resetn_i),
            .level_i(sense_sync_reg[i]),
            .time_i(deglitch_reg[CDHP_DEGL_TIME_LSB +: 7]),
            .bypass_i(deglitch_reg[CDHP_DEGL_BYPASS_BIT]),
            .det_o(det[i]) // [RULE_22]
        );

        always_comb begin
            cyc_next[i] = cyc_reg[i];
            step_next[i] = step_reg[i];
            dly_next[i] = dly_reg[i];
            if (!det[i]) begin
                // Every unplug forfeits progress, so each plug waits in full
                cyc_next[i] = '0; // [RULE_23]
                step_next[i] = 4'h0;
                dly_next[i] = 1'b0;
            end else if (!dly_reg[i]) begin
                if (step_reg[i] >= delay_sel) begin
                    dly_next[i] = 1'b1; // [RULE_18]
                end else if (cyc_reg[i] == HP_STEP_CYCLES - CDHP_STEP_W'(1)) begin
                    cyc_next[i] = '0;
                    step_next[i] = step_reg[i] + 4'h1;
                end else begin
                    cyc_next[i] = cyc_reg[i] + CDHP_STEP_W'(1);
                end
            end
        end

        always_ff @(posedge sys_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                cyc_reg[i] <= '0;
                step_reg[i] <= 4'h0;
                dly_reg[i] <= 1'b0;
            end else begin
                cyc_reg[i] <= cyc_next[i];
                step_reg[i] <= step_next[i];
                dly_reg[i] <= dly_next[i];
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Hot-plug level per port
        logic edid;
        logic live;

        assign edid = port_internal_edid_active_i[i]; // [RULE_20]
        // Falls use the undelayed detect so unplug acts at once
        assign live = dly_reg[i] & det[i];

        always_comb begin
            hp_next[i] = 1'b0;
            if (manual_sel) begin
                hp_next[i] = man_level[i]; // [RULE_11] [RULE_12] [RULE_13]
            end else begin
                unique case (policy)
                    CDHP_POL_EDID: hp_next[i] = edid; // [RULE_14]
                    CDHP_POL_CABLE: hp_next[i] = live; // [RULE_15]
                    CDHP_POL_EDID_CABLE: hp_next[i] = edid & live; // [RULE_16]
                    CDHP_POL_EDID_CABLE_MAN: hp_next[i] = edid & live & man_level[i]; // [RULE_17]
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    logic [3:0] flt_reg;
    logic rx_rst_reg;
    logic rx_rst_next;

    // A floating sense pin would hold reset forever unless disabled [RULE_10]
    assign rx_rst_next = !cable_rst_reg[CDHP_CABLE_RST_DIS_BIT] && !det[rx_port_sel_i]; // [RULE_09]

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hp_reg <= 4'h0;
            flt_reg <= 4'h0;
            rx_rst_reg <= 1'b1;
        end else begin
            hp_reg <= hp_next;
            flt_reg <= det; // [RULE_08]
            rx_rst_reg <= rx_rst_next; // [RULE_08]
        end
    end

    assign hotplug_pin_o = hp_reg;
    assign hotplug_pin_oe_o = ~hiz; // [RULE_19]
    assign cable_det_filtered_o = flt_reg;
    assign rx_section_reset_o = rx_rst_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_auto(logic [1:0] pol);
        !manual_sel && hp_policy_reg[CDHP_POLICY_LSB +: 2] == pol;
    endsequence

    AST_RAW_READBACK: assert property (reg_rd_i && reg_addr_i == CDHP_OFF_CABLE_RAW // [RULE_01]
        |=> reg_rdata_o == {4'h0, $past(sense_sync_reg)})
        else $error("raw cable readback mismatch");
    AST_MANUAL_FOLLOW: assert property (manual_sel |=> hotplug_pin_o == $past(man_level)) // [RULE_11]
        else $error("manual hot-plug level not driven");
    AST_POLICY_EDID: assert property (s_auto(2'b00) // [RULE_14]
        |=> hotplug_pin_o == $past(port_internal_edid_active_i))
        else $error("policy 00 does not follow E-EDID");
    AST_POLICY_UNPLUG: assert property (s_auto(2'b01) and (det == 4'h0) // [RULE_15]
        |=> hotplug_pin_o == 4'h0)
        else $error("policy 01 not deasserted on unplug");
    AST_POLICY_EDID_CABLE: assert property (s_auto(2'b10) // [RULE_16]
        |=> (hotplug_pin_o & ~$past(port_internal_edid_active_i & dly_reg)) == 4'h0)
        else $error("policy 10 asserted without both conditions");
    AST_POLICY_ALL: assert property (s_auto(2'b11) // [RULE_17]
        |=> (hotplug_pin_o & ~$past(port_internal_edid_active_i & dly_reg & man_level))
        == 4'h0)
        else $error("policy 11 asserted without all conditions");
    AST_DELAY_NEEDS_DET: assert property ((dly_reg & ~$past(dly_reg)) != 4'h0 // [RULE_23]
        |-> ((dly_reg & ~$past(dly_reg)) & ~$past(det)) == 4'h0)
        else $error("delayed detect rose without cable detect");
    AST_HIZ_ENABLE: assert property (reg_wr_i && reg_addr_i == CDHP_OFF_HP_MANUAL // [RULE_19]
        |=> hotplug_pin_oe_o == ~$past(reg_wdata_i[3:0]))
        else $error("tristate bit not reflected on enable");
    AST_CABLE_RST_DIS: assert property (cable_rst_reg[CDHP_CABLE_RST_DIS_BIT] // [RULE_09]
        |=> !rx_section_reset_o)
        else $error("receiver reset while cable reset disabled");

endmodule : cdhp_ctrl

// File: cdhp_ctrl_bench.sv
// Self-checking bench for the cable detect and hot-plug block.
// Assumes cdhp_pkg and cdhp_source_model are compiled first.
`define CHECK(got, exp, msg) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp); \
        end \
    end

module cdhp_ctrl_bench
    import cdhp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Short delay step keeps the run small
    localparam logic [20:0] STEP = 21'h000014;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [3:0] plug = 4'h0;
    logic [3:0] edid = 4'h0;
    logic [1:0] port_sel = 2'h3;
    logic [3:0] sense;
    logic [3:0] hp_pin;
    logic [3:0] hp_oe;
    logic [3:0] hp_seen;
    logic [3:0] det_filt;
    logic rx_rst;
    int err_count = 0;
    int samples_checked = 0;

    always #25 sys_clk = ~sys_clk;

    cdhp_ctrl #(.HP_STEP_CYCLES(STEP)) u_cdhp_ctrl (
        .sys_clk_i(sys_clk),
        .resetn_i(resetn),
        .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd),
        .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata),
        .port_supply_sense_i(sense),
        .port_internal_edid_active_i(edid),
        .rx_port_sel_i(port_sel),
        .hotplug_pin_o(hp_pin),
        .hotplug_pin_oe_o(hp_oe),
        .cable_det_filtered_o(det_filt),
        .rx_section_reset_o(rx_rst)
    );

    cdhp_source_model u_cdhp_source_model (
        .plug_i(plug),
        .hotplug_pin_i(hp_pin),
        .hotplug_pin_oe_i(hp_oe),
        .supply_sense_o(sense),
        .hotplug_seen_o(hp_seen)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string m);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        `CHECK(reg_rdata, e, m)
    endtask : rd_chk

    // 0 hot-plug line, 1 filtered detect, 2 receiver reset
    function automatic logic [3:0] pick(input int w);
        return w == 0 ? hp_seen : (w == 1 ? det_filt : {3'b000, rx_rst});
    endfunction : pick

    task automatic await(input int w, input logic [3:0] e, input int max, input string m);
        int i;
        // Step off the edge so a value launched there has settled
        #1;
        i = 0;
        while (pick(w) !== e && i < max) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        `CHECK(pick(w), e, m)
    endtask : await

    // Early exit keeps one glitch from flooding the log
    task automatic hold(input int w, input logic [3:0] e, input int n, input string m);
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            if (pick(w) !== e) break;
        end
        `CHECK(pick(w), e, m)
    endtask : hold

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        rd_chk(CDHP_OFF_HP_MANUAL, 8'h00, "manual reset");
        rd_chk(CDHP_OFF_CABLE_RST, 8'h00, "cable rst reset");
        rd_chk(CDHP_OFF_DEGLITCH, 8'h58, "deglitch reset");
        rd_chk(CDHP_OFF_HP_POLICY, 8'hA3, "policy reset");
        rd_chk(8'h33, 8'h00, "unmapped read");
        wr(CDHP_OFF_CABLE_RAW, 8'hFF);
        rd_chk(CDHP_OFF_CABLE_RAW, 8'h00, "raw read only");
        `CHECK(hp_oe, 4'hF, "oe after reset")
        `CHECK(rx_rst, 1'b1, "rx reset idle")
        $display("test reset values done");

        wr(CDHP_OFF_DEGLITCH, 8'h0A);
        @(posedge sys_clk);
        plug <= 4'h8;
        repeat (5) @(posedge sys_clk);
        plug <= 4'h0;
        hold(1, 4'h0, 12, "short pulse filtered");
        @(posedge sys_clk);
        plug <= 4'h8;
        hold(1, 4'h0, 14, "filter early");
        await(1, 4'h8, 2, "filter late");
        rd_chk(CDHP_OFF_CABLE_RAW, 8'h08, "raw port a");
        await(2, 4'h0, 4, "rx reset release");
        @(posedge sys_clk);
        plug <= 4'h0;
        await(1, 4'h0, 5, "filter drop");
        await(2, 4'h1, 4, "rx reset on unplug");
        wr(CDHP_OFF_CABLE_RST, 8'h40);
        await(2, 4'h0, 3, "rx reset disabled");
        wr(CDHP_OFF_CABLE_RST, 8'h00);
        wr(CDHP_OFF_DEGLITCH, 8'h80);
        @(posedge sys_clk);
        plug <= 4'h4;
        await(1, 4'h4, 4, "bypass detect");
        `CHECK(rx_rst, 1'b1, "rx reset other port")
        @(posedge sys_clk);
        port_sel <= 2'h2;
        await(2, 4'h0, 3, "rx reset follows select");
        $display("test deglitch done");

        wr(CDHP_OFF_HP_MANUAL, 8'hA5);
        await(0, 4'hA, 4, "manual levels");
        `CHECK(hp_oe, 4'hA, "tristate bits")
        rd_chk(CDHP_OFF_HP_STATUS, 8'h0A, "driven status");
        @(posedge sys_clk);
        edid <= 4'hF;
        wr(CDHP_OFF_HP_POLICY, 8'h01);
        hold(0, 4'hA, 5, "policy ignored");
        wr(CDHP_OFF_HP_MANUAL, 8'h00);
        $display("test manual done");

        @(posedge sys_clk);
        plug <= 4'h0;
        edid <= 4'h0;
        wr(CDHP_OFF_HP_POLICY, 8'h00);
        @(posedge sys_clk);
        edid <= 4'h6;
        await(0, 4'h6, 3, "edid rise");
        @(posedge sys_clk);
        edid <= 4'h2;
        await(0, 4'h2, 3, "edid fall");
        @(posedge sys_clk);
        edid <= 4'h0;
        wr(CDHP_OFF_HP_POLICY, 8'h22);
        @(posedge sys_clk);
        plug <= 4'h9;
        hold(0, 4'h0, 42, "delay too short");
        await(0, 4'h9, 4, "delayed rise");
        @(posedge sys_clk);
        plug <= 4'h1;
        await(0, 4'h1, 4, "unplug fall");
        @(posedge sys_clk);
        plug <= 4'h9;
        hold(0, 4'h1, 30, "delay restarted");
        await(0, 4'h9, 30, "replug rise");
        wr(CDHP_OFF_HP_POLICY, 8'h04);
        await(0, 4'h0, 3, "needs edid");
        @(posedge sys_clk);
        edid <= 4'h3;
        await(0, 4'h1, 4, "edid and cable");
        @(posedge sys_clk);
        plug <= 4'h8;
        await(0, 4'h0, 3, "cable lost");
        @(posedge sys_clk);
        plug <= 4'h9;
        edid <= 4'hF;
        wr(CDHP_OFF_HP_POLICY, 8'h06);
        hold(0, 4'h0, 6, "needs manual");
        wr(CDHP_OFF_HP_MANUAL, 8'h90);
        await(0, 4'h9, 6, "all three");
        wr(CDHP_OFF_HP_MANUAL, 8'h80);
        await(0, 4'h8, 3, "manual lost");
        rd_chk(CDHP_OFF_HP_STATUS, 8'h08, "auto status");
        wr(CDHP_OFF_HP_MANUAL, 8'h88);
        await(0, 4'h0, 3, "released line low");
        rd_chk(CDHP_OFF_HP_STATUS, 8'h00, "tristated status");
        $display("test policies done");
        final_report();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        err_count++;
        final_report();
    end
endmodule : cdhp_ctrl_bench

// File: cdhp_deglitch.sv
// Deglitch filter for one synchronised +5 V sense level.
// Assumes its input is already synchronised to sys_clk_i.
module cdhp_deglitch
    import cdhp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic level_i,
    input wire logic [6:0] time_i,
    input wire logic bypass_i,
    output logic det_o
);

    logic prev_reg;
    logic prev_next;
    logic [9:0] cnt_reg;
    logic [9:0] cnt_next;
    logic out_reg;
    logic out_next;
    logic [9:0] target;

    ////////////////////////////////////////////////////////////////////////////
    // Stability counter
    assign target = 10'({3'h0, time_i} * CDHP_DEGL_UNIT_CYCLES); // [RULE_05]

    always_comb begin
        prev_next = level_i;
        cnt_next = cnt_reg;
        out_next = out_reg;
        if (level_i != prev_reg) begin
            // Any edge kills the output at once
            cnt_next = 10'h000; // [RULE_04]
            out_next = 1'b0;
        end else if (level_i) begin
            if (cnt_reg >= target) begin
                out_next = 1'b1; // [RULE_03]
            end else begin
                cnt_next = cnt_reg + 10'h001;
            end
        end else begin
            cnt_next = 10'h000;
            out_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prev_reg <= 1'b0;
            cnt_reg <= 10'h000;
            out_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            cnt_reg <= cnt_next;
            out_reg <= out_next;
        end
    end

    // Bypass passes the synchronised level straight through
    assign det_o = bypass_i ? level_i : out_reg; // [RULE_06]

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_level_edge;
        !bypass_i && (level_i != prev_reg);
    endsequence

    sequence s_out_rise;
        !bypass_i && !out_reg ##1 out_reg;
    endsequence

    AST_FILT_DROP: assert property (s_level_edge |=> !out_reg) // [RULE_04]
        else $error("filter output not cleared on input change");
    AST_FILT_RISE: assert property (s_out_rise |-> $past(level_i) // [RULE_03]
        && $past(level_i == prev_reg) && $past(cnt_reg) >= $past(target))
        else $error("filter output rose before timer elapsed");
    AST_FILT_LOW: assert property (!bypass_i && !level_i |-> ##1 !out_reg) // [RULE_03]
        else $error("filter output high while input low");
    AST_FILT_BYPASS: assert property (bypass_i |-> det_o == level_i) // [RULE_06]
        else $error("bypassed filter does not follow input");

endmodule : cdhp_deglitch

// File: cdhp_pkg.sv
// Constants, register map and mode types for the cable detect and hot-plug block.
// Assumes a single 20 MHz system clock shared by every file of the block.
package cdhp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CDHP_CLK_HZ = 20_000_000;
    localparam int CDHP_CLK_PERIOD_NS = 50;
    // One deglitch unit, two ring-oscillator cycles
    localparam int CDHP_DEGL_UNIT_NS = 47;
    localparam logic [9:0] CDHP_DEGL_UNIT_CYCLES =
        10'((CDHP_DEGL_UNIT_NS + CDHP_CLK_PERIOD_NS - 1) / CDHP_CLK_PERIOD_NS);
    // One hot-plug delay step
    localparam int CDHP_HP_STEP_MS = 100;
    localparam int CDHP_STEP_W = 21;
    localparam logic [CDHP_STEP_W-1:0] CDHP_HP_STEP_CYCLES =
        CDHP_STEP_W'(CDHP_HP_STEP_MS * (CDHP_CLK_HZ / 1000));

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] CDHP_OFF_HP_MANUAL = 8'h20;
    localparam logic [7:0] CDHP_OFF_HP_STATUS = 8'h21;
    localparam logic [7:0] CDHP_OFF_CABLE_RST = 8'h48;
    localparam logic [7:0] CDHP_OFF_DEGLITCH = 8'h56;
    localparam logic [7:0] CDHP_OFF_HP_POLICY = 8'h6C;
    localparam logic [7:0] CDHP_OFF_CABLE_RAW = 8'h6F;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CDHP_MAN_LEVEL_LSB = 4;
    localparam int CDHP_HIZ_LSB = 0;
    localparam int CDHP_CABLE_RST_DIS_BIT = 6;
    localparam int CDHP_DEGL_BYPASS_BIT = 7;
    localparam int CDHP_DEGL_TIME_LSB = 0;
    localparam int CDHP_MANUAL_SEL_BIT = 0;
    localparam int CDHP_POLICY_LSB = 1;
    localparam int CDHP_DELAY_LSB = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] CDHP_RST_HP_MANUAL = 8'h00;
    localparam logic [7:0] CDHP_RST_CABLE_RST = 8'h00;
    localparam logic [7:0] CDHP_RST_DEGLITCH = 8'h58;
    localparam logic [7:0] CDHP_RST_HP_POLICY = 8'hA3;

    typedef enum logic [1:0] {
        CDHP_POL_EDID = 2'b00,
        CDHP_POL_CABLE = 2'b01,
        CDHP_POL_EDID_CABLE = 2'b10,
        CDHP_POL_EDID_CABLE_MAN = 2'b11
    } cdhp_policy_e;

endpackage : cdhp_pkg

// File: cdhp_source_model.sv
// Upstream source model: drives the +5 V sense pins, sees the hot-plug lines.
// Assumes the bench sets the cable state per port through plug_i.
module cdhp_source_model (
    input wire logic [3:0] plug_i,
    input wire logic [3:0] hotplug_pin_i,
    input wire logic [3:0] hotplug_pin_oe_i,
    output logic [3:0] supply_sense_o,
    output logic [3:0] hotplug_seen_o
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // Unplugged sense pin sits on a pull-down, so it reads low
    assign supply_sense_o = plug_i;
    // Sink pull-down: a released hot-plug line reads low, never the last value
    assign hotplug_seen_o = hotplug_pin_i & hotplug_pin_oe_i;
endmodule : cdhp_source_model
